// ### branch_bit_flag_exec_unit.v
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "exec_regs.vh"

module branch_bit_flag_exec_unit #(
    parameter PC_WIDTH = 16
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        exec_busy
);

    localparam ST_IDLE = 2'd0;
    localparam ST_EXEC = 2'd1;
    localparam ST_HOLD = 2'd2;
    localparam [PC_WIDTH-1:0] PC_ONE   = 1;
    localparam [PC_WIDTH-1:0] PC_RESET = 0;

    reg  [1:0]          state;
    reg  [15:0]         instr;
    reg  [7:0]          status_register;
    reg  [PC_WIDTH-1:0] pc;
    reg                 last_taken;
    reg                 last_illegal;
    reg  [7:0]          gpr [0:31];
    reg  [7:0]          io_space [0:63];

    reg                 aw_held;
    reg                 w_held;
    reg  [11:0]         aw_addr;
    reg  [31:0]         w_data;
    reg  [3:0]          w_strb;

    reg  [1:0]          next_state;
    reg  [PC_WIDTH-1:0] next_pc;
    reg  [7:0]          next_flags;
    reg                 gpr_we;
    reg  [7:0]          gpr_wd;
    reg                 io_we;
    reg  [7:0]          io_wd;
    reg                 taken;
    reg                 illegal;
    reg  [7:0]          shift_res;
    reg                 shift_c;

    integer i;

    wire [7:0]          gpr_rd = gpr[instr[4:0]];
    wire [7:0]          io_rd  = io_space[instr[10:5]];
    wire [2:0]          bit_sel = instr[10:8];
    wire [PC_WIDTH-1:0] k_ext = {{(PC_WIDTH-7){instr[6]}}, instr[6:0]};

    function [7:0] bit_mask;
        input [2:0] b;
        begin
            bit_mask = 8'h01 << b;
        end
    endfunction

    // Shifts leave S, H, T and I alone; V follows N xor C.
    function [7:0] shift_flags;
        input [7:0] s;
        input [7:0] r;
        input       c;
        begin
            shift_flags = s;
            shift_flags[`FLAG_C] = c;
            shift_flags[`FLAG_Z] = (r == 8'h00);
            shift_flags[`FLAG_N] = r[7];
            shift_flags[`FLAG_V] = r[7] ^ c;
        end
    endfunction

    assign exec_busy = (state != ST_IDLE);

    // Execution datapath
    always @* begin
        next_state = state;
        next_pc    = pc;
        next_flags = status_register;
        gpr_we     = 1'b0;
        gpr_wd     = gpr_rd;
        io_we      = 1'b0;
        io_wd      = io_rd;
        taken      = 1'b0;
        illegal    = 1'b0;
        shift_res  = gpr_rd;
        shift_c    = status_register[`FLAG_C];
        if (state == ST_HOLD) begin
            next_state = ST_IDLE;
        end else if (state == ST_EXEC) begin
            next_state = ST_IDLE;
            next_pc    = pc + PC_ONE;
            case (instr[15:12])
                `CLS_BRANCH: begin
                    // Any status bit against the set or clear form
                    taken = (status_register[bit_sel] == instr[11]);
                end
                `CLS_SIGNED: begin
                    taken = ((status_register[`FLAG_N] ^
                              status_register[`FLAG_V]) == instr[11]);
                end
                `CLS_IOBIT: begin
                    io_we = 1'b1;
                    if (instr[11]) begin
                        io_wd = io_rd | bit_mask(instr[2:0]);
                    end else begin
                        io_wd = io_rd & ~bit_mask(instr[2:0]);
                    end
                    next_state = ST_HOLD;
                end
                `CLS_SHIFT: begin
                    gpr_we = 1'b1;
                    case (instr[11:10])
                        `SH_LEFT: begin
                            shift_res = {gpr_rd[6:0], 1'b0};
                            shift_c   = gpr_rd[7];
                        end
                        `SH_RIGHT: begin
                            shift_res = {1'b0, gpr_rd[7:1]};
                            shift_c   = gpr_rd[0];
                        end
                        `SH_ROT: begin
                            shift_res = {status_register[`FLAG_C],
                                         gpr_rd[7:1]};
                            shift_c   = gpr_rd[0];
                        end
                        default: begin
                            shift_res = {gpr_rd[7], gpr_rd[7:1]};
                            shift_c   = gpr_rd[0];
                        end
                    endcase
                    gpr_wd    = shift_res;
                    next_flags = shift_flags(status_register, shift_res,
                                             shift_c);
                end
                `CLS_XFER: begin
                    if (instr[11]) begin
                        gpr_we = 1'b1;
                        gpr_wd = (gpr_rd & ~bit_mask(bit_sel)) |
                                 (status_register[`FLAG_T] ?
                                  bit_mask(bit_sel) : 8'h00);
                    end else begin
                        next_flags[`FLAG_T] = gpr_rd[bit_sel];
                    end
                end
                `CLS_FLAG: begin
                    // Index 7 is the global interrupt enable
                    next_flags[bit_sel] = instr[11];
                end
                default: begin
                    illegal = 1'b1;
                end
            endcase
            if (taken) begin
                next_pc    = pc + k_ext + PC_ONE;
                // The extra cycle stands for the discarded sequential fetch
                next_state = ST_HOLD;
            end
        end
    end

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire  = s_axi_wvalid && s_axi_wready;
    wire wr_go   = aw_held && w_held && !s_axi_bvalid;
    wire ar_fire = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire wr_gpr = (aw_addr[11:7] == `GPR_REGION);
    wire wr_io  = (aw_addr[11:8] == `IO_REGION);
    wire wr_known = (aw_addr == `OFF_INSTR) || (aw_addr == `OFF_STATUS) ||
                    (aw_addr == `OFF_FLAGS) || (aw_addr == `OFF_PC) ||
                    wr_gpr || wr_io;
    // A new instruction while one is running is refused, not queued
    wire wr_start = wr_go && (aw_addr == `OFF_INSTR) && !exec_busy &&
                    (w_strb[1:0] == 2'b11);
    // State writes while busy are dropped so they never race execution
    wire wr_state = wr_go && !exec_busy && w_strb[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 12'h000;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (w_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (!wr_known || ((aw_addr == `OFF_INSTR) && !wr_start)) begin
                    s_axi_bresp <= `RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `RESP_OKAY;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state           <= ST_IDLE;
            instr           <= 16'h0000;
            status_register <= `FLAGS_RESET;
            pc              <= PC_RESET;
            last_taken      <= 1'b0;
            last_illegal    <= 1'b0;
            for (i = 0; i < 32; i = i + 1) begin
                gpr[i] <= 8'h00;
            end
            for (i = 0; i < 64; i = i + 1) begin
                io_space[i] <= 8'h00;
            end
        end else begin
            state           <= next_state;
            pc              <= next_pc;
            status_register <= next_flags;
            if (gpr_we) begin
                gpr[instr[4:0]] <= gpr_wd;
            end
            if (io_we) begin
                io_space[instr[10:5]] <= io_wd;
            end
            if (state == ST_EXEC) begin
                last_taken   <= taken;
                last_illegal <= illegal;
            end
            if (wr_start) begin
                instr <= w_data[15:0];
                state <= ST_EXEC;
            end
            if (wr_state) begin
                if (aw_addr == `OFF_FLAGS) begin
                    status_register <= w_data[7:0];
                end
                if (aw_addr == `OFF_PC) begin
                    pc <= w_data[PC_WIDTH-1:0];
                end
                if (wr_gpr) begin
                    gpr[aw_addr[6:2]] <= w_data[7:0];
                end
                if (wr_io) begin
                    io_space[aw_addr[7:2]] <= w_data[7:0];
                end
            end
        end
    end

    wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (ra == `OFF_INSTR) begin
                s_axi_rdata <= {16'h0000, instr};
            end else if (ra == `OFF_STATUS) begin
                s_axi_rdata <= {29'h0000_0000, last_illegal, last_taken,
                                exec_busy};
            end else if (ra == `OFF_FLAGS) begin
                s_axi_rdata <= {24'h00_0000, status_register};
            end else if (ra == `OFF_PC) begin
                s_axi_rdata <= {{(32-PC_WIDTH){1'b0}}, pc};
            end else if (ra[11:7] == `GPR_REGION) begin
                s_axi_rdata <= {24'h00_0000, gpr[ra[6:2]]};
            end else if (ra[11:8] == `IO_REGION) begin
                s_axi_rdata <= {24'h00_0000, io_space[ra[7:2]]};
            end else begin
                s_axi_rresp <= `RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ### branch_bit_flag_exec_unit_tb.sv
`timescale 1ns/100ps
`include "exec_regs.vh"
module branch_bit_flag_exec_unit_tb;
    reg         aclk;
    reg         aresetn;
    wire [11:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    wire        s_axi_rvalid, s_axi_rready, exec_busy, hang;
    integer     error_cnt, compares, bc, i;
    reg  [31:0] q;
    reg  [1:0]  r;
    reg  [7:0]  f, v, e;
    reg         c, tk;
    branch_bit_flag_exec_unit i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_busy
    );
    exec_unit_host i_host (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hang
    );
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (exec_busy === 1'b1)
            bc <= bc + 1;
        if (hang === 1'b1) begin
            error_cnt = error_cnt + 1;
            end_sim;
        end
    end
    task end_sim;
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] x);
        compares = compares + 1;
        if (s !== x) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        i_host.xfer(1'b1, a, d, q, r);
        chk(r, `RESP_OKAY);
    endtask
    task rchk(input [11:0] a, input [31:0] x);
        i_host.xfer(1'b0, a, 32'h0, q, r);
        chk(q, x);
    endtask
    // Runs one instruction and counts the cycles the core stays occupied
    task ex(input [15:0] op, input integer n);
        integer k;
        bc = 0;
        wr(`OFF_INSTR, {16'h0, op});
        q = 32'h1;
        for (k = 0; k < 16 && q[0] !== 1'b0; k = k + 1)
            i_host.xfer(1'b0, `OFF_STATUS, 32'h0, q, r);
        chk(q[0], 1'b0);
        if (q[0] !== 1'b0)
            end_sim;
        chk(bc, n);
    endtask
    task t_branch;
        for (i = 0; i < 32; i = i + 1) begin
            f = i[4] ? 8'h5a : 8'ha5;
            tk = f[i[2:0]] == i[3];
            wr(`OFF_FLAGS, f);
            wr(`OFF_PC, 32'h10);
            ex({4'h0, i[3:0], 1'b0, 7'h7d}, tk ? 2 : 1);
            rchk(`OFF_PC, tk ? 32'he : 32'h11);
            rchk(`OFF_STATUS, {tk, 1'b0});
            rchk(`OFF_FLAGS, f);
        end
    endtask
    task t_signed;
        for (i = 0; i < 8; i = i + 1) begin
            tk = (i[1] ^ i[0]) == i[2];
            wr(`OFF_FLAGS, {4'h0, i[1:0], 2'h0});
            wr(`OFF_PC, 32'h10);
            ex({4'h1, i[2], 11'h003}, tk ? 2 : 1);
            rchk(`OFF_PC, tk ? 32'h14 : 32'h11);
        end
    endtask
    task t_iobit;
        wr(`OFF_FLAGS, 8'h3c);
        wr(12'h114, 8'h5a);
        ex({4'h2, 1'b1, 6'd5, 5'd0}, 2);
        rchk(12'h114, 8'h5b);
        ex({4'h2, 1'b0, 6'd5, 5'd6}, 2);
        rchk(12'h114, 8'h1b);
        rchk(`OFF_FLAGS, 8'h3c);
    endtask
    task t_shift;
        for (i = 0; i < 8; i = i + 1) begin
            v = i[2] ? 8'h01 : 8'h81;
            case (i[1:0])
                2'h0: {c, e} = {v, 1'b0};
                2'h1: {e, c} = {1'b0, v};
                2'h2: {e, c} = {1'b1, v};
                default: {e, c} = {v[7], v};
            endcase
            wr(`OFF_FLAGS, 8'hf1);
            wr(12'h088, v);
            ex({4'h3, i[1:0], 5'h0, 5'd2}, 1);
            rchk(12'h088, e);
            rchk(`OFF_FLAGS, {4'hf, e[7]^c, e[7], e==0, c});
        end
    endtask
    task t_xfer;
        wr(`OFF_FLAGS, 8'h0);
        wr(12'h08c, 8'h04);
        wr(12'h090, 8'h0);
        ex({4'h4, 1'b0, 3'd2, 3'd0, 5'd3}, 1);
        rchk(`OFF_FLAGS, 8'h40);
        ex({4'h4, 1'b1, 3'd7, 3'd0, 5'd4}, 1);
        rchk(12'h090, 8'h80);
        ex({4'h4, 1'b0, 3'd0, 3'd0, 5'd3}, 1);
        rchk(`OFF_FLAGS, 8'h0);
    endtask
    task t_flag;
        for (i = 0; i < 16; i = i + 1) begin
            f = i[3] ? 8'h0 : 8'hff;
            wr(`OFF_FLAGS, f);
            ex({4'h5, i[3:0], 8'h0}, 1);
            rchk(`OFF_FLAGS, f ^ (8'h1 << i[2:0]));
        end
    endtask
    task t_misc;
        i_host.xfer(1'b0, 12'h010, 32'h0, q, r);
        chk(r, `RESP_SLVERR);
        chk(q, 32'h0);
        i_host.xfer(1'b1, 12'h010, 32'h0, q, r);
        chk(r, `RESP_SLVERR);
        ex(16'h6000, 1);
        rchk(`OFF_STATUS, 32'h4);
    endtask
    initial begin
        aresetn = 1'b0;
        error_cnt = 0;
        compares = 0;
        bc = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`OFF_FLAGS, `FLAGS_RESET);
        t_branch;
        t_signed;
        t_iobit;
        t_shift;
        t_xfer;
        t_flag;
        t_misc;
        end_sim;
    end
endmodule

// ### exec_regs.vh
`ifndef EXEC_REGS_VH
`define EXEC_REGS_VH

// Register byte offsets on the AXI4-Lite bus
`define OFF_INSTR        12'h000
`define OFF_STATUS       12'h004
`define OFF_FLAGS        12'h008
`define OFF_PC           12'h00c
// Working registers at 0x080..0x0fc, I/O space at 0x100..0x1fc
`define GPR_REGION       5'h01
`define IO_REGION        4'h1

// Status register bit positions
`define FLAG_C           0
`define FLAG_Z           1
`define FLAG_N           2
`define FLAG_V           3
`define FLAG_S           4
`define FLAG_H           5
`define FLAG_T           6
`define FLAG_I           7
`define FLAGS_RESET      8'h00

// Unit status bits
`define STAT_BUSY        0
`define STAT_TAKEN       1
`define STAT_ILLEGAL     2

// Instruction classes in bits 15:12
`define CLS_BRANCH       4'h0
`define CLS_SIGNED       4'h1
`define CLS_IOBIT        4'h2
`define CLS_SHIFT        4'h3
`define CLS_XFER         4'h4
`define CLS_FLAG         4'h5

// Shift operations in bits 11:10
`define SH_LEFT          2'h0
`define SH_RIGHT         2'h1
`define SH_ROT           2'h2
`define SH_ARITH         2'h3

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ### exec_unit_host.sv
`timescale 1ns/100ps
module exec_unit_host (
    input  wire        aclk,
    output reg  [11:0] s_axi_awaddr,
    output reg         s_axi_awvalid,
    input  wire        s_axi_awready,
    output reg  [31:0] s_axi_wdata,
    output reg         s_axi_wvalid,
    input  wire        s_axi_wready,
    input  wire [1:0]  s_axi_bresp,
    input  wire        s_axi_bvalid,
    output reg         s_axi_bready,
    output reg  [11:0] s_axi_araddr,
    output reg         s_axi_arvalid,
    input  wire        s_axi_arready,
    input  wire [31:0] s_axi_rdata,
    input  wire [1:0]  s_axi_rresp,
    input  wire        s_axi_rvalid,
    output reg         s_axi_rready,
    output reg         hang
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
        hang = 1'b0;
    end
    // Handshakes are judged half a period early, so no decision races the
    // edge that moves the readies
    task xfer(input w, input [11:0] a, input [31:0] d,
              output [31:0] q, output [1:0] r);
        integer n;
        reg     ta, tw, tr, dn;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_bready  <= w;
        s_axi_arvalid <= !w;
        s_axi_rready  <= !w;
        dn = 1'b0;
        for (n = 0; n < 64 && !dn; n = n + 1) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            dn = w ? s_axi_bvalid : s_axi_rvalid;
            q  = s_axi_rdata;
            r  = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (tr)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!dn)
            hang <= 1'b1;
    endtask
endmodule

// ### exec_unit_monitor.sv
`timescale 1ns/100ps
module exec_unit_monitor (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        exec_busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp not held");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata not held");
    property p_b_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_b_resp: assert property (p_b_resp) else $error("no write response");
    property p_r_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_resp: assert property (p_r_resp) else $error("no read response");
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write taken early");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done) else $error("bvalid repeated");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("rvalid repeated");
    // Nothing in this unit may occupy the core beyond two cycles
    property p_busy_len;
        $rose(exec_busy) |-> ##[1:2] !exec_busy;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
endmodule
bind branch_bit_flag_exec_unit exec_unit_monitor i_mon (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .exec_busy
);
